//--- hdl/smbus_control_status.v
// Control and status register of the two-wire unit with its bus-side hooks.
// Assumes a byte engine reports bus events on sys_clk and obeys the requests.
// Assumes the SFR bus presents address, page, byte and bit strobes on sys_clk.
`timescale 1ns/1ps
`include "smbus_defs.vh"
module smbus_control_status (
	input wire sys_clk,
	input wire rst,
	input wire [7:0] sfr_addr,
	input wire [7:0] sfr_page,
	input wire sfr_wr,
	input wire [7:0] sfr_wdata,
	input wire sfr_bit_wr,
	input wire [2:0] sfr_bit_sel,
	input wire sfr_bit_val,
	input wire sfr_rd,
	output reg [7:0] sfr_rdata_ff,
	output wire sfr_hit,
	input wire scl_in,
	input wire sda_in,
	output wire scl_out,
	output wire scl_oe,
	input wire eng_master,
	input wire eng_transmit,
	input wire eng_ack_request,
	input wire eng_arb_lost,
	input wire eng_event,
	input wire eng_ack_valid,
	input wire eng_ack_rx,
	input wire eng_start_done,
	input wire eng_stop_done,
	output wire start_request,
	output wire stop_request,
	output wire ack_send,
	output reg advance_ff,
	output wire bus_stall
);
	localparam ST_IDLE = 3'b001;
	localparam ST_START = 3'b010;
	localparam ST_RUN = 3'b100;

	reg master_ff;
	reg transmit_ff;
	reg start_ff;
	reg stop_ff;
	reg ackreq_ff;
	reg arblost_ff;
	reg ack_ff;
	reg int_ff;
	reg start_req_ff;
	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	reg [7:0] wr_mask;
	reg [7:0] wr_val;
	wire scl_level;
	wire sda_level;
	wire start_seen;
	wire stop_seen;
	wire busy;
	wire wr_hit;
	wire [7:0] ctrl_value;

	// Register decode for address and page
	function addr_hit;
		input [7:0] addr;
		input [7:0] page;
		begin
			addr_hit = (addr == `CTRL_SFR_ADDR) && (page == `CTRL_SFR_PAGE);
		end
	endfunction

	// One-hot mask of a bit index
	function [7:0] bit_mask;
		input [2:0] sel;
		begin
			bit_mask = 8'h01 << sel;
		end
	endfunction

	pin_sync scl_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.pin_in(scl_in),
		.pin_ff(scl_level)
	);

	pin_sync sda_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.pin_in(sda_in),
		.pin_ff(sda_level)
	);

	bus_condition_detect cond_det (
		.sys_clk(sys_clk),
		.rst(rst),
		.scl_level(scl_level),
		.sda_level(sda_level),
		.start_seen_ff(start_seen),
		.stop_seen_ff(stop_seen),
		.busy_ff(busy)
	);

	assign sfr_hit = addr_hit(sfr_addr, sfr_page);
	assign wr_hit = sfr_hit & (sfr_wr | sfr_bit_wr);

	always @* begin
		wr_mask = 8'h00;
		wr_val = 8'h00;
		if (wr_hit) begin
			if (sfr_wr) begin
				wr_mask = `CTRL_WR_MASK;
				wr_val = sfr_wdata;
			end else begin
				wr_mask = bit_mask(sfr_bit_sel) & `CTRL_WR_MASK;
				wr_val = sfr_bit_val ? bit_mask(sfr_bit_sel) : 8'h00;
			end
		end
	end

	// Register image for readback
	assign ctrl_value = {master_ff, transmit_ff, start_ff, stop_ff,
		ackreq_ff, arblost_ff, ack_ff, int_ff};

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sfr_rdata_ff <= `CTRL_RESET;
		end else if (sfr_rd & sfr_hit) begin
			sfr_rdata_ff <= ctrl_value;
		end
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			master_ff <= 1'b0;
			transmit_ff <= 1'b0;
			ackreq_ff <= 1'b0;
		end else begin
			master_ff <= eng_master;
			transmit_ff <= eng_transmit;
			ackreq_ff <= eng_ack_request;
		end
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			start_ff <= 1'b0;
		end else if (start_seen) begin
			start_ff <= 1'b1;
		end else if (wr_mask[`BIT_START]) begin
			start_ff <= wr_val[`BIT_START];
		end
	end

	// Start generation sequencer
	always @* begin
		case (state_ff)
			ST_IDLE: begin
				if (wr_mask[`BIT_START] & wr_val[`BIT_START]) begin
					nxt_state = ST_START;
				end else begin
					nxt_state = ST_IDLE;
				end
			end
			ST_START: begin
				if (eng_start_done | eng_arb_lost) begin
					nxt_state = ST_RUN;
				end else if (wr_mask[`BIT_START] & ~wr_val[`BIT_START]) begin
					nxt_state = ST_IDLE;
				end else begin
					nxt_state = ST_START;
				end
			end
			ST_RUN: begin
				if (wr_mask[`BIT_START] & wr_val[`BIT_START]) begin
					nxt_state = ST_START;
				end else begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_ff <= ST_IDLE;
			start_req_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			start_req_ff <= (nxt_state == ST_START);
		end
	end
	assign start_request = start_req_ff;

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stop_ff <= 1'b0;
		end else if (stop_seen & ~master_ff) begin
			stop_ff <= 1'b1;
		end else if (wr_mask[`BIT_STOP] & wr_val[`BIT_STOP]) begin
			stop_ff <= 1'b1;
		end else if (eng_stop_done) begin
			stop_ff <= 1'b0;
		end else if (wr_mask[`BIT_STOP]) begin
			stop_ff <= 1'b0;
		end
	end
	assign stop_request = stop_ff & master_ff;

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			arblost_ff <= 1'b0;
		end else if (eng_arb_lost) begin
			arblost_ff <= 1'b1;
		end else if (start_seen & ~busy) begin
			arblost_ff <= 1'b0;
		end else if (wr_mask[`BIT_INT] & ~wr_val[`BIT_INT]) begin
			arblost_ff <= 1'b0;
		end
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ack_ff <= 1'b0;
		end else if (eng_ack_valid) begin
			ack_ff <= eng_ack_rx;
		end else if (wr_mask[`BIT_ACK]) begin
			ack_ff <= wr_val[`BIT_ACK];
		end
	end
	assign ack_send = ack_ff;

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			int_ff <= 1'b0;
			advance_ff <= 1'b0;
		end else begin
			advance_ff <= wr_mask[`BIT_INT] & ~wr_val[`BIT_INT] & ~eng_event;
			if (eng_event) begin
				int_ff <= 1'b1;
			end else if (wr_mask[`BIT_INT]) begin
				int_ff <= wr_val[`BIT_INT];
			end
		end
	end

	assign scl_out = 1'b0;
	assign scl_oe = int_ff;
	assign bus_stall = int_ff;
endmodule

//--- common/smbus_defs.vh
// Constants of the two-wire bus control register block.
// Assumes inclusion by bare name from the hdl design files.
`ifndef SMBUS_DEFS_VH
`define SMBUS_DEFS_VH

// Register location and reset value
`define CTRL_SFR_ADDR 8'hC0
`define CTRL_SFR_PAGE 8'h00
`define CTRL_RESET 8'h00

// Field positions
`define BIT_MASTER 3'h7
`define BIT_TXMODE 3'h6
`define BIT_START 3'h5
`define BIT_STOP 3'h4
`define BIT_ACKREQ 3'h3
`define BIT_ARBLOST 3'h2
`define BIT_ACK 3'h1
`define BIT_INT 3'h0

// Software-writable bits
`define CTRL_WR_MASK 8'h33

// Pin synchroniser depth
`define SYNC_STAGES 3

`endif

//--- hdl/pin_sync.v
// Three-stage synchroniser for one pin with an agreement filter.
// Assumes the pin is asynchronous to sys_clk; idle level is high.
`timescale 1ns/1ps
module pin_sync (
	input wire sys_clk,
	input wire rst,
	input wire pin_in,
	output reg pin_ff
);
	reg s1_ff;
	reg s2_ff;
	reg s3_ff;

	// First stage feeds only the second
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s1_ff <= 1'b1;
			s2_ff <= 1'b1;
			s3_ff <= 1'b1;
			pin_ff <= 1'b1;
		end else begin
			s1_ff <= pin_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff) begin
				pin_ff <= s3_ff;
			end
		end
	end
endmodule

//--- hdl/bus_condition_detect.v
// Detects START and STOP conditions from synchronised clock and data levels.
// Assumes both inputs are already filtered on sys_clk.
`timescale 1ns/1ps
module bus_condition_detect (
	input wire sys_clk,
	input wire rst,
	input wire scl_level,
	input wire sda_level,
	output reg start_seen_ff,
	output reg stop_seen_ff,
	output reg busy_ff
);
	reg sda_prev_ff;
	reg scl_prev_ff;
	wire nxt_start;
	wire nxt_stop;

	// Data falls or rises while clock stays high
	assign nxt_start = scl_level & scl_prev_ff & sda_prev_ff & ~sda_level;
	assign nxt_stop = scl_level & scl_prev_ff & ~sda_prev_ff & sda_level;

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sda_prev_ff <= 1'b1;
			scl_prev_ff <= 1'b1;
			start_seen_ff <= 1'b0;
			stop_seen_ff <= 1'b0;
			busy_ff <= 1'b0;
		end else begin
			sda_prev_ff <= sda_level;
			scl_prev_ff <= scl_level;
			start_seen_ff <= nxt_start;
			stop_seen_ff <= nxt_stop;
			if (nxt_start) begin
				busy_ff <= 1'b1;
			end else if (nxt_stop) begin
				busy_ff <= 1'b0;
			end
		end
	end
endmodule

//--- verification/smbus_control_status_checker.sv
// Port checker for the two-wire bus control register.
// Assumes one sys_clk domain and the bind at the foot.
`timescale 1ns/1ps
module smbus_control_status_checker (
	input wire sys_clk,
	input wire rst,
	input wire [7:0] sfr_addr,
	input wire [7:0] sfr_page,
	input wire sfr_wr,
	input wire [7:0] sfr_wdata,
	input wire sfr_bit_wr,
	input wire sfr_rd,
	input wire [7:0] sfr_rdata_ff,
	input wire sfr_hit,
	input wire scl_out,
	input wire scl_oe,
	input wire eng_event,
	input wire eng_ack_valid,
	input wire eng_start_done,
	input wire start_request,
	input wire ack_send,
	input wire advance_ff,
	input wire bus_stall
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire wr_hit = sfr_hit && sfr_wr;
	chk_hit_decode: assert property (sfr_hit == (sfr_addr == 8'hC0 && sfr_page == 8'h00))
		else $error("decode wrong");
	chk_read_unmapped: assert property (sfr_rd && !sfr_hit |=> $stable(sfr_rdata_ff))
		else $error("read data moved");
	chk_scl_held: assert property (scl_oe == bus_stall && !scl_out)
		else $error("clock hold wrong");
	chk_event_sets: assert property (eng_event |=> bus_stall)
		else $error("flag not set");
	chk_flag_sticky: assert property (bus_stall && !(sfr_hit && (sfr_wr || sfr_bit_wr))
		|=> bus_stall)
		else $error("flag dropped");
	chk_force_int: assert property (wr_hit && sfr_wdata[0] |=> bus_stall)
		else $error("force failed");
	chk_clear_advance: assert property (wr_hit && !sfr_wdata[0] && bus_stall && !eng_event
		|=> !bus_stall && advance_ff ##1 !advance_ff)
		else $error("advance wrong");
	chk_start_req: assert property (wr_hit && sfr_wdata[5] && !eng_start_done |=> start_request)
		else $error("no start request");
	chk_start_drop: assert property (eng_start_done && !wr_hit && !(sfr_hit && sfr_bit_wr)
		|=> !start_request)
		else $error("start request stuck");
	chk_ack_select: assert property (wr_hit && !eng_ack_valid |=> ack_send == $past(sfr_wdata[1]))
		else $error("ack select wrong");
	cover property (advance_ff);
	cover property (eng_start_done ##1 !start_request);
	cover property (sfr_rd && !sfr_hit);
endmodule
bind smbus_control_status smbus_control_status_checker smbus_control_status_checker_inst (.*);

//--- verification/bus_peer.sv
// Far-side bus party that frames START and STOP on the pins.
// Assumes open-drain lines with pull-ups resolved in the bench.
`timescale 1ns/1ps
module bus_peer (
	output logic scl_low,
	output logic sda_low
);
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	task automatic start_cond;
		sda_low = 1'b1;
		#200 scl_low = 1'b1;
		#200;
	endtask
	task automatic stop_cond;
		sda_low = 1'b1;
		#200 scl_low = 1'b0;
		#200 sda_low = 1'b0;
		#200;
	endtask
endmodule

//--- verification/smbus_control_status_tb.sv
// Self-checking bench for the two-wire bus control register.
// Assumes the peer model and checker are compiled alongside.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
	$display("Error t=%0t got %h exp %h", $time, a, b); end end
module smbus_control_status_tb;
	logic sys_clk = 0, rst = 1, sfr_wr = 0, sfr_bit_wr = 0, sfr_bit_val = 0, sfr_rd = 0;
	logic [7:0] sfr_addr = 8'hC0, sfr_page = 8'h00, sfr_wdata = 8'h00, v;
	logic [2:0] sfr_bit_sel = 3'h0;
	logic eng_master = 0, eng_transmit = 0, eng_ack_request = 0, eng_arb_lost = 0;
	logic eng_event = 0, eng_ack_valid = 0, eng_ack_rx = 0, eng_start_done = 0, eng_stop_done = 0;
	wire [7:0] sfr_rdata_ff;
	wire sfr_hit, scl_out, scl_oe, start_request, stop_request, ack_send, advance_ff, bus_stall;
	wire scl_low, sda_low;
	wire scl_in = !(scl_low || scl_oe);
	wire sda_in = !sda_low;
	int err_total = 0, n_checks = 0;
	always #25 sys_clk = ~sys_clk;
	smbus_control_status smbus_control_status_inst (.*);
	bus_peer bus_peer_inst (.scl_low(scl_low), .sda_low(sda_low));
	task automatic wr(input [7:0] d);
		@(posedge sys_clk) begin sfr_wr <= 1'b1; sfr_wdata <= d; end
		@(posedge sys_clk) sfr_wr <= 1'b0;
		@(negedge sys_clk);
	endtask
	task automatic bwr(input [2:0] s, input b);
		@(posedge sys_clk) begin sfr_bit_wr <= 1'b1; sfr_bit_sel <= s; sfr_bit_val <= b; end
		@(posedge sys_clk) sfr_bit_wr <= 1'b0;
		@(negedge sys_clk);
	endtask
	task automatic rd;
		@(posedge sys_clk) sfr_rd <= 1'b1;
		@(posedge sys_clk) sfr_rd <= 1'b0;
		@(negedge sys_clk) v = sfr_rdata_ff;
	endtask
	localparam int P_STOP = 0, P_START = 1, P_ARB = 2, P_EVT = 3, P_ACK = 4;
	task automatic drive_eng(input int w, input logic b);
		case (w)
			P_STOP: eng_stop_done <= b;
			P_START: eng_start_done <= b;
			P_ARB: eng_arb_lost <= b;
			P_EVT: eng_event <= b;
			default: eng_ack_valid <= b;
		endcase
	endtask
	task automatic pulse(input int w);
		@(posedge sys_clk) drive_eng(w, 1'b1);
		@(posedge sys_clk) drive_eng(w, 1'b0);
		@(negedge sys_clk);
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		stop_test;
	end
	initial begin
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		rd; `CHK(v, 8'h00)
		wr(8'hFF); rd; `CHK(v, 8'h33)
		`CHK(scl_oe, 1'b1)
		`CHK(stop_request, 1'b0)
		@(posedge sys_clk) {eng_master, eng_transmit, eng_ack_request} <= 3'h7;
		rd; `CHK(v, 8'hFB)
		`CHK(stop_request, 1'b1)
		pulse(P_STOP); rd; `CHK(v[4], 1'b0)
		pulse(P_START); `CHK(start_request, 1'b0)
		wr(8'h20); `CHK(advance_ff, 1'b1)
		`CHK(scl_oe, 1'b0)
		`CHK(start_request, 1'b1)
		`CHK(ack_send, 1'b0)
		pulse(P_ARB); rd; `CHK(v[2], 1'b1)
		pulse(P_EVT); `CHK(scl_oe, 1'b1)
		repeat (3) @(negedge sys_clk);
		`CHK(bus_stall, 1'b1)
		bwr(3'h0, 1'b0); `CHK(bus_stall, 1'b0)
		rd; `CHK(v[2], 1'b0)
		bwr(3'h1, 1'b1); `CHK(ack_send, 1'b1)
		pulse(P_ACK); rd; `CHK(v[1], 1'b0)
		bwr(3'h7, 1'b0); rd; `CHK(v[7], 1'b1)
		@(posedge sys_clk) sfr_addr <= 8'hC1;
		wr(8'h01); rd; `CHK(v[7], 1'b1)
		`CHK(bus_stall, 1'b0)
		@(posedge sys_clk) begin sfr_addr <= 8'hC0; eng_master <= 1'b0; end
		wr(8'h00);
		bus_peer_inst.start_cond;
		repeat (10) @(negedge sys_clk);
		rd; `CHK(v[5], 1'b1)
		bus_peer_inst.stop_cond;
		repeat (10) @(negedge sys_clk);
		rd; `CHK(v[4], 1'b1)
		stop_test;
	end
endmodule
